// [hdl/pll_ratio_config.sv]
// Purpose: PLL ratio and CPU PLL divider registers with tick outputs
// Assumes: Plain register port, read data one cycle after the strobe
// Notes:   Clock cycles stand in for oscillator edges
`timescale 1ns/1ps
`include "pll_ratio_defines.svh"

module pll_ratio_config (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        write_in,
  input  wire logic        read_in,
  output logic      [31:0] rdata_out,
  output logic             pll_enable_out,
  output logic      [2:0]  pre_divider_ratio_out,
  output logic      [6:0]  multiplier_ratio_out,
  output logic             ratio_permitted_out,
  output logic             cpu_pll_output_out,
  output logic             cpu_clock_tick_out
);

  // ********************************
  // Reset release
  // ********************************
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rst_sync_q <= 2'h0;
    end
    else
    begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ********************************
  // Functions
  // ********************************
  function automatic logic pair_ok(input logic [1:0] pre, input logic [5:0] mult);
    pair_ok = (pre == `PRE_CODE_1 && mult == `MULT_CODE_60)
           || (pre == `PRE_CODE_2 && mult == `MULT_CODE_60)
           || (pre == `PRE_CODE_2 && mult == `MULT_CODE_48)
           || (pre == `PRE_CODE_2 && mult == `MULT_CODE_40)
           || (pre == `PRE_CODE_3 && mult == `MULT_CODE_60);
  endfunction

  function automatic logic csid_legal(input logic [2:0] csid);
    csid_legal = (csid >= `CSID_DIV1) && (csid <= `CSID_DIV8);
  endfunction

  function automatic logic [3:0] csid_ratio(input logic [2:0] csid);
    unique case (csid)
      `CSID_DIV2: csid_ratio = 4'h2;
      `CSID_DIV4: csid_ratio = 4'h4;
      `CSID_DIV8: csid_ratio = 4'h8;
      default:    csid_ratio = 4'h1;
    endcase
  endfunction

  function automatic logic [31:0] ratio_word(input logic [1:0] pre, input logic [5:0] mult);
    ratio_word = (`RATIO_RESET & ~`RATIO_RW_MASK)
               | ({19'h0, pre, 11'h0})
               | ({26'h0, mult});
  endfunction

  // ********************************
  // State
  // ********************************
  pll_ratio_pkg::ctl_state_t s_q;
  pll_ratio_pkg::ctl_state_t s_d;
  logic [31:0]               read_word;
  logic [31:0]               status_word;
  logic                      ratio_wr;
  logic                      div_wr;
  logic [1:0]                wr_pre;
  logic [5:0]                wr_mult;
  logic [2:0]                wr_csid;
  logic [1:0]                wr_divpll;
  logic                      pll_tick;

  assign wr_pre    = wdata_in[`PRE_MSB:`PRE_LSB];
  assign wr_mult   = wdata_in[`MULT_MSB:`MULT_LSB];
  assign wr_csid   = wdata_in[`CSID_MSB:`CSID_LSB];
  assign wr_divpll = wdata_in[`DIVPLL_MSB:`DIVPLL_LSB];
  // Locked while running, so the loop never sees a ratio step
  assign ratio_wr  = write_in && addr_in == `RATIO_ADDR && !s_q.en;
  // Prohibited divider codes are dropped whole
  assign div_wr    = write_in && addr_in == `CPU_DIV_ADDR
                  && wr_divpll == `DIVPLL_SIX && csid_legal(wr_csid);

  always_comb
  begin
    status_word                  = 32'h0;
    status_word[`EN_BIT]         = s_q.en;
    status_word[`STAT_OK_BIT]    = s_q.pair_ok;
    status_word[`STAT_MR_LSB+:3] = s_q.mr;
    status_word[`STAT_NR_LSB+:7] = s_q.nr;
  end

  // ********************************
  // Read decode
  // ********************************
  always_comb
  begin
    read_word = 32'h0;
    unique case (addr_in)
      `CTRL_ADDR:    read_word[`EN_BIT] = s_q.en;
      `STATUS_ADDR:  read_word = status_word;
      `RATIO_ADDR:   read_word = ratio_word(s_q.pre, s_q.mult);
      `CPU_DIV_ADDR: read_word = {27'h0, `DIVPLL_SIX, s_q.csid};
      default:       read_word = 32'h0;
    endcase
  end

  // ********************************
  // Next state
  // ********************************
  always_comb
  begin
    s_d       = s_q;
    s_d.rdata = read_in ? read_word : 32'h0;
    if (write_in && addr_in == `CTRL_ADDR)
    begin
      s_d.en = wdata_in[`EN_BIT];
    end
    if (ratio_wr)
    begin
      s_d.pre  = wr_pre;
      s_d.mult = wr_mult;
    end
    if (div_wr)
    begin
      s_d.csid = wr_csid;
    end
    s_d.mr      = 3'({1'b0, s_d.pre} + 3'h1);
    s_d.nr      = 7'({1'b0, s_d.mult} + 7'h01);
    s_d.pair_ok = pair_ok(s_d.pre, s_d.mult);
  end

  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q         <= '0;
      s_q.pre     <= `RESET_PRE;
      s_q.mult    <= `RESET_MULT;
      s_q.csid    <= `RESET_CSID;
      s_q.mr      <= `RESET_MR;
      s_q.nr      <= `RESET_NR;
      s_q.pair_ok <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ********************************
  // Clock dividers
  // ********************************
  pulse_divider u_vco_div (
    .clock_in (clock_in),
    .rst_n_in (rst_n),
    .run_in   (s_q.en),
    .step_in  (s_q.en),
    .ratio_in (`VCO_DIVISOR),
    .tick_out (pll_tick)
  );

  pulse_divider u_cpu_div (
    .clock_in (clock_in),
    .rst_n_in (rst_n),
    .run_in   (s_q.en),
    .step_in  (pll_tick),
    .ratio_in (csid_ratio(s_q.csid)),
    .tick_out (cpu_clock_tick_out)
  );

  assign rdata_out             = s_q.rdata;
  assign pll_enable_out        = s_q.en;
  assign pre_divider_ratio_out = s_q.mr;
  assign multiplier_ratio_out  = s_q.nr;
  assign ratio_permitted_out   = s_q.pair_ok;
  assign cpu_pll_output_out    = pll_tick;

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n);

  a_locked_ratio_held: assert property (
    (write_in && addr_in == `RATIO_ADDR && s_q.en)
      |=> ($stable(s_q.pre) && $stable(s_q.mult) && $stable(s_q.en)))
    else $error("ratio changed while PLL enabled");

  a_reset_ratio_value: assert property (
    (rst_n && !$past(rst_n))
      |-> (ratio_word(s_q.pre, s_q.mult) == `RATIO_RESET))
    else $error("ratio not at reset value after reset");

  a_word_read_back: assert property (
    (read_in && addr_in == `RATIO_ADDR && !write_in)
      |=> (rdata_out == ratio_word(s_q.pre, s_q.mult)))
    else $error("ratio read data wrong");

  a_reserved_bits: assert property (
    $past(read_in && addr_in == `RATIO_ADDR)
      |-> ((rdata_out & ~`RATIO_RW_MASK) == (`RATIO_RESET & ~`RATIO_RW_MASK)))
    else $error("reserved ratio bits wrong");

  a_pre_field_write: assert property (
    (write_in && addr_in == `RATIO_ADDR && !s_q.en)
      |=> (s_q.pre == $past(wdata_in[`PRE_MSB:`PRE_LSB])
           && s_q.mr == 3'($past(wdata_in[`PRE_MSB:`PRE_LSB])) + 3'h1))
    else $error("pre-divider field not taken");

  a_mult_field_ratio: assert property (
    (write_in && addr_in == `RATIO_ADDR && !s_q.en)
      |=> (s_q.mult == $past(wdata_in[`MULT_MSB:`MULT_LSB])
           && multiplier_ratio_out == 7'($past(wdata_in[`MULT_MSB:`MULT_LSB])) + 7'h01))
    else $error("multiplier field not taken");

  a_divide_by_six: assert property (
    (pll_tick && s_q.en) ##1 s_q.en[*5] |=> pll_tick)
    else $error("CPU PLL output not divided by six");

  a_no_early_tick: assert property (
    pll_tick |=> !pll_tick[*5])
    else $error("CPU PLL output tick too early");

  a_divpll_zero: assert property (
    $past(read_in && addr_in == `CPU_DIV_ADDR)
      |-> (rdata_out[`DIVPLL_MSB:`DIVPLL_LSB] == `DIVPLL_SIX))
    else $error("CPU PLL divider code not zero");

  c_locked_write: cover property (write_in && addr_in == `RATIO_ADDR && s_q.en);
  c_ratio_write:  cover property (ratio_wr ##1 ratio_permitted_out);
  c_pll_tick:     cover property (pll_tick ##6 pll_tick);
  c_cpu_tick:     cover property (cpu_clock_tick_out && s_q.csid == `CSID_DIV8);

endmodule

// [include/pll_ratio_defines.svh]
// Purpose: Addresses, field positions, reset values and codes
// Assumes: 32-bit register words at byte addresses
// Notes:   Definitions only
`ifndef PLL_RATIO_DEFINES_SVH
`define PLL_RATIO_DEFINES_SVH

// ********************************
// Register addresses
// ********************************
`define CTRL_ADDR      32'hFFF89000
`define STATUS_ADDR    32'hFFF89004
`define RATIO_ADDR     32'hFFF89008
`define CPU_DIV_ADDR   32'hFFF8A100

// ********************************
// Ratio register layout
// ********************************
`define RATIO_RESET    32'h0001133B
`define RATIO_RW_MASK  32'h0000183F
`define PRE_MSB        12
`define PRE_LSB        11
`define MULT_MSB       5
`define MULT_LSB       0
`define RESET_PRE      2'h2
`define RESET_MULT     6'h3B
`define RESET_MR       3'h3
`define RESET_NR       7'h3C
`define PRE_CODE_1     2'h0
`define PRE_CODE_2     2'h1
`define PRE_CODE_3     2'h2
`define MULT_CODE_60   6'h3B
`define MULT_CODE_48   6'h2F
`define MULT_CODE_40   6'h27

// ********************************
// CPU divider register layout
// ********************************
`define CPU_DIV_RESET  32'h00000001
`define DIVPLL_MSB     4
`define DIVPLL_LSB     3
`define CSID_MSB       2
`define CSID_LSB       0
`define DIVPLL_SIX     2'h0
`define CSID_DIV1      3'h1
`define CSID_DIV2      3'h2
`define CSID_DIV4      3'h3
`define CSID_DIV8      3'h4
`define RESET_CSID     3'h1
`define VCO_DIVISOR    4'h6

// ********************************
// Control and status layout
// ********************************
`define EN_BIT         0
`define STAT_OK_BIT    1
`define STAT_MR_LSB    8
`define STAT_NR_LSB    16

`endif

// [include/pll_ratio_pkg.sv]
// Purpose: State types of the PLL ratio block
// Assumes: Nothing
// Notes:   Constants live in the defines header
package pll_ratio_pkg;

  typedef struct packed {
    logic        en;
    logic [1:0]  pre;
    logic [5:0]  mult;
    logic [2:0]  csid;
    logic [2:0]  mr;
    logic [6:0]  nr;
    logic        pair_ok;
    logic [31:0] rdata;
  } ctl_state_t;

  typedef struct packed {
    logic [3:0] count;
    logic       tick;
  } div_state_t;

endpackage

// [hdl/pulse_divider.sv]
// Purpose: Divides a step pulse stream by a ratio into tick pulses
// Assumes: Ratio between 1 and 15
// Notes:   Counter clears whenever run_in is low
`timescale 1ns/1ps

module pulse_divider (
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire logic       run_in,
  input  wire logic       step_in,
  input  wire logic [3:0] ratio_in,
  output logic            tick_out
);

  pll_ratio_pkg::div_state_t s_q;
  pll_ratio_pkg::div_state_t s_d;

  // ********************************
  // Next state
  // ********************************
  always_comb
  begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    if (!run_in)
    begin
      s_d.count = 4'h0;
    end
    else if (step_in)
    begin
      // Ratio zero behaves as one
      if (s_q.count + 4'h1 >= ratio_in)
      begin
        s_d.count = 4'h0;
        s_d.tick  = 1'b1;
      end
      else
      begin
        s_d.count = s_q.count + 4'h1;
      end
    end
  end

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign tick_out = s_q.tick;

endmodule

// [dv/pll_ratio_config_tb_top.sv]
// Purpose: Self-checking bench for the PLL ratio block
// Assumes: Read data stands only in the cycle after the read strobe
// Notes:   Expected read words wait in a queue for the monitor
`timescale 1ns/1ps
`include "pll_ratio_defines.svh"

module pll_ratio_config_tb_top;
  logic        clock_in;
  logic        rst_n_in;
  logic [31:0] addr_in;
  logic [31:0] wdata_in;
  logic        write_in;
  logic        read_in;
  logic [31:0] rdata_out;
  logic        pll_enable_out;
  logic [2:0]  pre_divider_ratio_out;
  logic [6:0]  multiplier_ratio_out;
  logic        ratio_permitted_out;
  logic        cpu_pll_output_out;
  logic        cpu_clock_tick_out;
  logic        rd_d;
  logic [31:0] exp_q[$];
  logic [31:0] rnd;
  logic [31:0] ratio_exp;
  logic [7:0]  pairs [5] = '{8'h3B, 8'h7B, 8'h6F, 8'h67, 8'hBB};
  int          num_errors = 0;
  int          tests_run = 0;
  int          cycles = 0;

  pll_ratio_config dut (
    .clock_in              (clock_in),
    .rst_n_in              (rst_n_in),
    .addr_in               (addr_in),
    .wdata_in              (wdata_in),
    .write_in              (write_in),
    .read_in               (read_in),
    .rdata_out             (rdata_out),
    .pll_enable_out        (pll_enable_out),
    .pre_divider_ratio_out (pre_divider_ratio_out),
    .multiplier_ratio_out  (multiplier_ratio_out),
    .ratio_permitted_out   (ratio_permitted_out),
    .cpu_pll_output_out    (cpu_pll_output_out),
    .cpu_clock_tick_out    (cpu_clock_tick_out)
  );

  always #5 clock_in = ~clock_in;

  // ********************************
  // Compare and bus tasks
  // ********************************
  task automatic chk_read(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: read got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_level(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: level got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr_in  <= a;
    wdata_in <= d;
    write_in <= 1'b1;
    @(posedge clock_in);
    write_in <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    @(posedge clock_in);
    addr_in <= a;
    read_in <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock_in);
    read_in <= 1'b0;
  endtask

  // Write then read with no gap, the tightest legal spacing
  task automatic wr_rd(input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
    wr(a, d);
    read_in <= 1'b1;
    exp_q.push_back(e);
    @(posedge clock_in);
    read_in <= 1'b0;
  endtask

  function automatic logic tick(input bit sel);
    return sel ? cpu_clock_tick_out : cpu_pll_output_out;
  endfunction

  // Cycles between two ticks; bounded so a dead tick cannot hang
  task automatic period(input bit sel, input logic [31:0] exp);
    int n;
    n = 0;
    while (tick(sel) !== 1'b1 && n < 60)
    begin
      @(negedge clock_in);
      n++;
    end
    n = 0;
    do
    begin
      @(negedge clock_in);
      n++;
    end while (tick(sel) !== 1'b1 && n < 60);
    chk_level(32'(n), exp);
  endtask

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ********************************
  // Monitor and timeout
  // ********************************
  always @(posedge clock_in)
    rd_d <= read_in;

  always @(negedge clock_in)
    if (rd_d === 1'b1)
      chk_read(rdata_out, exp_q.pop_front());

  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      test_done();
    end
  end

  initial
  begin
    clock_in = 1'b0;
    rst_n_in = 1'b0;
    addr_in  = 32'h0;
    wdata_in = 32'h0;
    write_in = 1'b0;
    read_in  = 1'b0;
    void'($urandom(32'h4e643d2e));
    repeat (8) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    rd(`RATIO_ADDR, `RATIO_RESET);
    rd(`CPU_DIV_ADDR, `CPU_DIV_RESET);
    rd(`STATUS_ADDR, 32'h003C0302);
    wr_rd(`RATIO_ADDR, 32'h00010B27, 32'h00010B27);
    // Every listed pair must be flagged as permitted
    for (int i = 0; i < 5; i++)
    begin
      ratio_exp = (`RATIO_RESET & ~`RATIO_RW_MASK) | {19'h0, pairs[i][7:6], 5'h0, pairs[i][5:0]};
      wr_rd(`RATIO_ADDR, ratio_exp, ratio_exp);
      @(negedge clock_in);
      chk_level(32'(ratio_permitted_out), 32'h1);
      chk_level(32'(pre_divider_ratio_out), 32'(pairs[i][7:6]) + 32'h1);
      chk_level(32'(multiplier_ratio_out), 32'(pairs[i][5:0]) + 32'h1);
    end
    // Deliberate unlisted pair: stored, but flagged as not permitted
    wr(`RATIO_ADDR, 32'h0001032F);
    @(negedge clock_in);
    chk_level(32'(ratio_permitted_out), 32'h0);
    // Random listed pairs, reserved bits written at their reset values
    repeat (4)
    begin
      rnd = 32'($urandom_range(4));
      ratio_exp = (`RATIO_RESET & ~`RATIO_RW_MASK) | {19'h0, pairs[rnd][7:6], 5'h0, pairs[rnd][5:0]};
      wr_rd(`RATIO_ADDR, ratio_exp, ratio_exp);
      @(negedge clock_in);
      chk_level(32'(multiplier_ratio_out), 32'(ratio_exp[5:0]) + 32'h1);
      chk_level(32'(ratio_permitted_out), 32'h1);
    end
    wr_rd(`RATIO_ADDR, 32'h00010B27, 32'h00010B27);
    // Input clock taken as calibrated before the loop is enabled
    wr(`CTRL_ADDR, 32'h00000001);
    @(negedge clock_in);
    chk_level(32'(pll_enable_out), 32'h1);
    wr_rd(`RATIO_ADDR, 32'h0001133B, 32'h00010B27);
    @(negedge clock_in);
    chk_level(32'(multiplier_ratio_out), 32'd40);
    period(1'b0, 32'd6);
    wr_rd(`CPU_DIV_ADDR, 32'h00000009, `CPU_DIV_RESET);
    wr(`CPU_DIV_ADDR, 32'h00000002);
    period(1'b1, 32'd12);
    wr(`CPU_DIV_ADDR, 32'h00000003);
    period(1'b1, 32'd24);
    wr(`CPU_DIV_ADDR, 32'h00000004);
    period(1'b1, 32'd48);
    wr_rd(32'hFFF89010, 32'hFFFFFFFF, 32'h0);
    // Second reset in mid-run, with the PLL running
    @(posedge clock_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    rd(`RATIO_ADDR, `RATIO_RESET);
    rd(`CTRL_ADDR, 32'h0);
    rd(`CPU_DIV_ADDR, `CPU_DIV_RESET);
    repeat (3) @(posedge clock_in);
    test_done();
  end
endmodule
